//--- hdl/add_subtract_datapath.sv
// add and subtract execution datapath with flags and pc-relative forms
`timescale 1ns/1ps
`include "addsub_regs.svh"
module add_subtract_datapath (
    input wire logic clk,
    input wire logic srst,
    input wire logic issue_valid,
    input wire addsub_pkg::arith_op_t op,
    input wire addsub_pkg::cond_t cond,
    input wire logic flag_update_suffix,
    input wire logic use_twelve_bit_immediate,
    input wire logic [`TWELVE_BIT_IMMEDIATE_W-1:0] twelve_bit_immediate,
    input wire logic [`REG_IDX_W-1:0] first_operand_reg,
    input wire logic [`DATA_W-1:0] first_operand_value,
    input wire logic [`DATA_W-1:0] flexible_operand,
    input wire logic dest_present,
    input wire logic [`REG_IDX_W-1:0] dest_reg,
    output logic wr_valid,
    output logic [`REG_IDX_W-1:0] wr_reg,
    output logic [`DATA_W-1:0] wr_data,
    output logic branch_valid,
    output logic [`DATA_W-1:0] branch_target,
    output logic flag_n,
    output logic flag_z,
    output logic flag_c,
    output logic flag_v
);
    import addsub_pkg::*;

    // ************************************
    // condition evaluation
    // ************************************
    logic cond_pass;
    always_comb begin
        case (cond)
            cond_eq: cond_pass = flag_z;
            cond_ne: cond_pass = !flag_z;
            cond_cs: cond_pass = flag_c;
            cond_cc: cond_pass = !flag_c;
            cond_mi: cond_pass = flag_n;
            cond_pl: cond_pass = !flag_n;
            cond_vs: cond_pass = flag_v;
            cond_vc: cond_pass = !flag_v;
            cond_hi: cond_pass = flag_c && !flag_z;
            cond_ls: cond_pass = !flag_c || flag_z;
            cond_ge: cond_pass = flag_n == flag_v;
            cond_lt: cond_pass = flag_n != flag_v;
            cond_gt: cond_pass = !flag_z && (flag_n == flag_v);
            cond_le: cond_pass = flag_z || (flag_n != flag_v);
            default: cond_pass = 1'b1;
        endcase
    end

    // ************************************
    // operand selection
    // ************************************
    logic wide_form;
    logic [`DATA_W-1:0] base_value;
    logic [`DATA_W-1:0] second_value;
    logic [`DATA_W-1:0] adder_a;
    logic [`DATA_W-1:0] adder_b;
    logic adder_cin;
    logic [`DATA_W-1:0] sum;
    logic sum_cout;
    logic sum_ovf;
    logic [`REG_IDX_W-1:0] target_reg;
    logic pc_dest;

    assign wide_form = (op == op_wide_imm_add) || (op == op_wide_imm_difference);

    always_comb begin
        base_value = first_operand_value;
        if (first_operand_reg == `PC_IDX) begin
            base_value = {first_operand_value[`DATA_W-1:2], 2'b00};
        end
        // immediate zero-extended, full 0..4095 range
        if (use_twelve_bit_immediate || wide_form) begin
            second_value = {{(`DATA_W-`TWELVE_BIT_IMMEDIATE_W){1'b0}}, twelve_bit_immediate};
        end else begin
            second_value = flexible_operand;
        end
    end

    // subtraction as a + ~b + 1 so carry out is the not-borrow flag
    always_comb begin
        adder_a = base_value;
        adder_b = second_value;
        adder_cin = 1'b0;
        case (op)
            op_add, op_wide_imm_add: begin
                adder_cin = 1'b0;
            end
            op_add_with_carry: begin
                adder_cin = flag_c;
            end
            op_difference, op_wide_imm_difference: begin
                adder_b = ~second_value;
                adder_cin = 1'b1;
            end
            op_borrow_difference: begin
                adder_b = ~second_value;
                adder_cin = flag_c;
            end
            op_reversed_difference: begin
                adder_a = second_value;
                adder_b = ~base_value;
                adder_cin = 1'b1;
            end
            default: begin
                adder_cin = 1'b0;
            end
        endcase
    end

    carry_adder u_adder (
        .a(adder_a),
        .b(adder_b),
        .cin(adder_cin),
        .sum(sum),
        .cout(sum_cout),
        .ovf(sum_ovf)
    );

    assign target_reg = dest_present ? dest_reg : first_operand_reg;
    assign pc_dest = (target_reg == `PC_IDX);

    // ************************************
    // result writeback
    // ************************************
    // a failed condition leaves every architectural output quiet
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_valid <= 1'b0;
            wr_reg <= '0;
            wr_data <= '0;
        end else begin
            wr_valid <= issue_valid && cond_pass && !pc_dest;
            if (issue_valid && cond_pass && !pc_dest) begin
                wr_reg <= target_reg;
                wr_data <= sum;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            branch_valid <= 1'b0;
            branch_target <= '0;
        end else begin
            branch_valid <= issue_valid && cond_pass && pc_dest;
            if (issue_valid && cond_pass && pc_dest) begin
                branch_target <= {sum[`DATA_W-1:1], 1'b0};
            end
        end
    end

    // ************************************
    // condition flags
    // ************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            {flag_n, flag_z, flag_c, flag_v} <= `FLAGS_RESET;
        end else if (issue_valid && cond_pass && flag_update_suffix) begin
            flag_n <= sum[`DATA_W-1];
            flag_z <= (sum == '0);
            flag_c <= sum_cout;
            flag_v <= sum_ovf;
        end
    end
endmodule : add_subtract_datapath

//--- hdl/addsub_regs.svh
// constants for the add and subtract datapath
// Functional notes
// - add gives first operand plus flexible operand or twelve-bit immediate.
// - add with carry also adds the current carry flag.
// - difference gives first operand minus flexible operand or immediate.
// - borrow difference subtracts one more when carry is clear.
// - reversed difference gives flexible operand minus first operand.
// - twelve-bit immediate is unsigned, zero up to 4095.
// - with no destination encoded, result goes back to first operand register.
// - flag suffix updates N, Z, C, V; otherwise flags hold.
// - program counter as operand has its low two bits forced to zero.
// - add writing program counter clears result bit zero and branches.
// - wide immediate add and difference match the immediate add and difference.
`ifndef ADDSUB_REGS_SVH
`define ADDSUB_REGS_SVH
`define DATA_W 32
`define REG_IDX_W 4
`define TWELVE_BIT_IMMEDIATE_W 12
`define TWELVE_BIT_IMMEDIATE_MAX 12'hfff
`define PC_IDX 4'hf
`define SP_IDX 4'hd
`define FLAG_N 3
`define FLAG_Z 2
`define FLAG_C 1
`define FLAG_V 0
`define FLAGS_RESET 4'h0
`endif

//--- hdl/addsub_pkg.sv
// types for the add and subtract datapath
package addsub_pkg;
    typedef enum logic [2:0] {
        op_add,
        op_add_with_carry,
        op_difference,
        op_borrow_difference,
        op_reversed_difference,
        op_wide_imm_add,
        op_wide_imm_difference
    } arith_op_t;
    typedef enum logic [3:0] {
        cond_eq, cond_ne, cond_cs, cond_cc, cond_mi, cond_pl, cond_vs, cond_vc,
        cond_hi, cond_ls, cond_ge, cond_lt, cond_gt, cond_le, cond_al, cond_nv
    } cond_t;
endpackage : addsub_pkg

//--- hdl/carry_adder.sv
// 32-bit adder with carry in, carry out and signed overflow
`timescale 1ns/1ps
`include "addsub_regs.svh"
module carry_adder (
    input wire logic [`DATA_W-1:0] a,
    input wire logic [`DATA_W-1:0] b,
    input wire logic cin,
    output logic [`DATA_W-1:0] sum,
    output logic cout,
    output logic ovf
);
    logic [`DATA_W:0] full;
    always_comb begin
        full = {1'b0, a} + {1'b0, b} + {{`DATA_W{1'b0}}, cin};
        sum = full[`DATA_W-1:0];
        cout = full[`DATA_W];
        ovf = (a[`DATA_W-1] == b[`DATA_W-1]) && (sum[`DATA_W-1] != a[`DATA_W-1]);
    end
endmodule : carry_adder

//--- tb/addsub_sva.sv
// concurrent checks on the add and subtract datapath ports
`timescale 1ns/1ps
`include "addsub_regs.svh"
module addsub_sva (
    input wire logic clk, srst, issue_valid, flag_update_suffix, use_twelve_bit_immediate, dest_present,
    input wire addsub_pkg::arith_op_t op,
    input wire addsub_pkg::cond_t cond,
    input wire logic [11:0] twelve_bit_immediate,
    input wire logic [3:0] first_operand_reg, dest_reg, wr_reg,
    input wire logic [31:0] first_operand_value, flexible_operand, wr_data, branch_target,
    input wire logic wr_valid, branch_valid, flag_n, flag_z, flag_c, flag_v
);
    import addsub_pkg::*;
    logic [3:0] dst, f;
    logic [31:0] a, b;
    logic go;
    assign f = {flag_n, flag_z, flag_c, flag_v};
    assign dst = dest_present ? dest_reg : first_operand_reg;
    assign a = first_operand_reg == `PC_IDX ? first_operand_value & ~32'h3 : first_operand_value;
    assign b = use_twelve_bit_immediate ? {20'h0, twelve_bit_immediate} : flexible_operand;
    // only unconditional issues, so no flag decoding is needed here
    assign go = issue_valid && cond >= cond_al;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_run(arith_op_t o);
        go && op == o && dst != `PC_IDX;
    endsequence
    a_add_sum: assert property (s_run(op_add) |=> wr_data == $past(a + b))
        else $error("bad sum");
    a_wide_add: assert property (s_run(op_wide_imm_add)
        |=> wr_data == $past(a + {20'h0, twelve_bit_immediate})) else $error("bad wide sum");
    a_diff_carry: assert property (s_run(op_difference) ##0 flag_update_suffix
        |=> flag_c == $past(a >= b) && wr_data == $past(a - b)) else $error("bad diff");
    a_branch_form: assert property (go && dst == `PC_IDX
        |=> branch_valid && !wr_valid && branch_target == $past((a + flexible_operand) & ~32'h1))
        else $error("bad branch");
    a_dest_default: assert property (go && !dest_present && dst != `PC_IDX
        |=> wr_valid && wr_reg == $past(first_operand_reg)) else $error("bad dest");
    a_flags_hold: assert property (issue_valid && !flag_update_suffix |=> $stable(f))
        else $error("flags moved");
    a_cond_quiet: assert property (issue_valid && cond == cond_eq && !flag_z
        |=> !wr_valid && !branch_valid && $stable(f)) else $error("failed cond acted");
    a_nz_flags: assert property (go && flag_update_suffix && dst != `PC_IDX
        |=> flag_z == (wr_data == 0) && flag_n == wr_data[31]) else $error("bad nz");
endmodule : addsub_sva
bind add_subtract_datapath addsub_sva u_addsub_sva (.*);

//--- tb/addsub_decode_model.sv
// decode stage model issuing random legal add and subtract instructions
`timescale 1ns/1ps
`include "addsub_regs.svh"
module addsub_decode_model (
    input wire logic clk, srst,
    output addsub_pkg::arith_op_t op,
    output addsub_pkg::cond_t cond,
    output logic issue_valid, flag_update_suffix, use_twelve_bit_immediate, dest_present,
    output logic [11:0] twelve_bit_immediate,
    output logic [3:0] first_operand_reg, dest_reg,
    output logic [31:0] first_operand_value, flexible_operand
);
    import addsub_pkg::*;
    integer seed = 69;
    logic [31:0] r, v;
    logic [2:0] o;
    initial forever begin
        r = $random(seed);
        v = $random(seed);
        o = 3'($unsigned($random(seed)) % 7);
        issue_valid <= r[0] && srst === 1'b0;
        op <= arith_op_t'(o);
        cond <= cond_t'(r[7:4]);
        flag_update_suffix <= r[8];
        use_twelve_bit_immediate <= r[9] && o != 3'h1 && o != 3'h3;
        twelve_bit_immediate <= r[10] ? `TWELVE_BIT_IMMEDIATE_MAX : v[11:0];
        first_operand_reg <= r[15:12];
        first_operand_value <= v;
        // equal operands make zero results likely
        flexible_operand <= r[16] ? v : $random(seed);
        dest_present <= r[17];
        dest_reg <= r[21:18];
        if (r[15:12] == `PC_IDX) begin
            op <= r[22] ? op_add : op_difference;
            flag_update_suffix <= 1'b0;
            use_twelve_bit_immediate <= 1'b1;
            dest_present <= 1'b1;
            dest_reg <= {1'b0, r[20:18]};
        end else if (r[17] && r[21:18] == `PC_IDX) begin
            op <= op_add;
            first_operand_reg <= `PC_IDX;
            use_twelve_bit_immediate <= 1'b0;
            flag_update_suffix <= 1'b0;
        end else if ((r[17] ? r[21:18] : r[15:12]) == `SP_IDX) begin
            op <= r[22] ? op_add : op_difference;
            first_operand_reg <= `SP_IDX;
        end
        @(negedge clk);
    end
endmodule : addsub_decode_model

//--- tb/add_subtract_datapath_tb_top.sv
// self-checking bench for the add and subtract datapath
`timescale 1ns/1ps
`include "addsub_regs.svh"
module add_subtract_datapath_tb_top;
    import addsub_pkg::*;
    logic clk = 0, srst = 1, issue_valid, flag_update_suffix, use_twelve_bit_immediate, dest_present;
    arith_op_t op;
    cond_t cond;
    logic [11:0] twelve_bit_immediate;
    logic [3:0] first_operand_reg, dest_reg, wr_reg, er, d, mf;
    logic [31:0] first_operand_value, flexible_operand, wr_data, branch_target, ed, et, a, b, y;
    logic wr_valid, branch_valid, flag_n, flag_z, flag_c, flag_v, ev, eb, ci, sb;
    logic [32:0] s;
    logic [15:0] t;
    int err_count = 0, n_compared = 0;
    always #2 clk = ~clk;
    addsub_decode_model u_addsub_decode_model (.*);
    add_subtract_datapath u_add_subtract_datapath (.*);
    task compare(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare
    task results;
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    always @(posedge clk) begin
        if (srst) begin
            {mf, ev, eb, er, ed, et} = '0;
        end else begin
            {ev, eb} = 2'b00;
            t = {2'b11, mf[2] | (mf[3] ^ mf[0]), !mf[2] && !(mf[3] ^ mf[0]), mf[3] ^ mf[0],
                !(mf[3] ^ mf[0]), !mf[1] | mf[2], mf[1] && !mf[2], !mf[0], mf[0], !mf[3], mf[3],
                !mf[1], mf[1], !mf[2], mf[2]};
            if (issue_valid && t[cond]) begin
                a = first_operand_reg == `PC_IDX ? first_operand_value & ~32'h3 : first_operand_value;
                b = use_twelve_bit_immediate || op >= op_wide_imm_add ? {20'h0, twelve_bit_immediate} : flexible_operand;
                sb = op inside {op_difference, op_borrow_difference, op_reversed_difference,
                    op_wide_imm_difference};
                ci = op inside {op_add_with_carry, op_borrow_difference} ? mf[1] : sb;
                if (op == op_reversed_difference) {a, b} = {b, a};
                y = sb ? ~b : b;
                s = {1'b0, a} + {1'b0, y} + {32'h0, ci};
                d = dest_present ? dest_reg : first_operand_reg;
                if (d == `PC_IDX) {eb, et} = {1'b1, s[31:1], 1'b0};
                else {ev, er, ed} = {1'b1, d, s[31:0]};
                if (flag_update_suffix) mf = {s[31], s[31:0] == 0, s[32], a[31] == y[31] && s[31] != a[31]};
            end
        end
    end
    always @(negedge clk) begin
        if (!srst) begin
            compare({wr_valid, wr_reg}, {ev, er});
            compare(wr_data, ed);
            compare({branch_valid, branch_target}, {eb, et});
            compare({flag_n, flag_z, flag_c, flag_v}, mf);
        end
    end
    initial begin
        repeat (10) @(negedge clk);
        srst <= 0;
        repeat (3000) @(negedge clk);
        srst <= 1;
        @(negedge clk);
        srst <= 0;
        repeat (3000) @(negedge clk);
        results;
    end
    initial begin
        #30000;
        err_count++;
        results;
    end
endmodule : add_subtract_datapath_tb_top
